// [core/bsx_defines.svh]
// Offsets, field positions, reset values and timing counts of the bit/shift/flag execution unit
`ifndef BSX_DEFINES_SVH
`define BSX_DEFINES_SVH

// ==========================================
// Flag register bit positions
`define BSX_FLAG_C 3'd0
`define BSX_FLAG_Z 3'd1
`define BSX_FLAG_N 3'd2
`define BSX_FLAG_V 3'd3
`define BSX_FLAG_S 3'd4
`define BSX_FLAG_H 3'd5
`define BSX_FLAG_T 3'd6
`define BSX_FLAG_I 3'd7

// ==========================================
// Register port offsets
`define BSX_REG_ADDR_W 2
`define BSX_OFS_FLAGS 2'h0
`define BSX_OFS_NVM_WAIT 2'h1
`define BSX_OFS_STATUS 2'h2

// ==========================================
// Reset values
`define BSX_FLAGS_RST 8'h00
`define BSX_NVM_WAIT_RST 4'h1

// ==========================================
// Timing: least extra wait of a data access through the memory controller; stall bit position in the status register
`define BSX_NVM_WAIT_MIN_CYC 4'h1
`define BSX_STATUS_STALL_BIT 0

`endif

// [core/bsx_exec_unit.sv]
// Bit, shift, flag and core control execution unit
// Function
// RULE_01: Logical left shift moves bits up, zero into bit 0, old bit 7 to carry, updates Z C N V H in one cycle.
// RULE_02: Logical right shift moves bits down, zero into bit 7, old bit 0 to carry, updates Z C N V in one cycle.
// RULE_03: Rotate left through carry puts old carry in bit 0, bit 7 to carry, updates Z C N V H in one cycle.
// RULE_04: Rotate right through carry puts old carry in bit 7, bit 0 to carry, updates Z C N V in one cycle.
// RULE_05: Arithmetic right shift shifts down keeping the sign bit, updates Z C N V in one cycle.
// RULE_06: Nibble exchange swaps the two halves of the destination in one cycle with no flag change.
// RULE_07: I/O bit set and clear force one bit of the addressed location, keep the rest, touch no flag, one cycle.
// RULE_08: Bit store copies a chosen source bit into the transfer flag only, in one cycle.
// RULE_09: Bit load copies the transfer flag into a chosen destination bit in one cycle, no flag change.
// RULE_10: Generic flag set and clear write one or zero to the flag picked by the bit index, one cycle.
// RULE_11: Dedicated set and clear exist for C N Z S V T H, each touching only its own flag.
// RULE_12: Global interrupt enable and disable set or clear the interrupt flag in one cycle.
// RULE_13: The idle operation takes one cycle and changes nothing.
// RULE_14: Watchdog restart, breakpoint and sleep entry each issue a one-cycle request and change no flag.
// RULE_15: A data access through the memory controller adds at least one wait cycle, more while it is busy.
// RULE_16: For shifts and rotates Z is set on a zero result, N is result bit 7, V is N xor C.
// RULE_17: Arithmetic right shift moves old bit 0 into carry.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "bsx_defines.svh"

module bsx_exec_unit
  import bsx_pkg::*;
#(
  parameter int IoAddrW = 5,
  parameter int WaitW = 4
)
(
  // Clock and reset
  input wire logic sysClk,
  input wire logic nrst,
  // Request from decode
  input wire logic opValid,
  input wire bsx_req_t opReq,
  input wire logic [IoAddrW-1:0] ioAddr,
  output logic opReady,
  // Memory controller state
  input wire logic nvmBusy,
  // Results
  output bsx_res_t result,
  output logic [IoAddrW-1:0] ioAddrOut,
  output logic nvmDone,
  output bsx_ctl_t ctlReq,
  output logic [7:0] flags,
  // Register port
  input wire logic [`BSX_REG_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData
);

  // ==========================================
  // State
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  bsx_res_t result_q;
  bsx_res_t result_d;
  logic [IoAddrW-1:0] ioAddr_q;
  bsx_ctl_t ctl_q;
  bsx_ctl_t ctl_d;
  logic [WaitW-1:0] nvmWait_q;
  logic [7:0] rdData_q;
  logic take;
  logic nvmStart;
  logic nvmStall;

  // ==========================================
  // Helpers
  function automatic logic [2:0] dedicatedFlag(input bsx_op_t op);
    unique case (op)
      OP_CARRY_SET, OP_CARRY_CLEAR: dedicatedFlag = `BSX_FLAG_C;
      OP_NEG_SET, OP_NEG_CLEAR: dedicatedFlag = `BSX_FLAG_N;
      OP_ZERO_SET, OP_ZERO_CLEAR: dedicatedFlag = `BSX_FLAG_Z;
      OP_SIGN_SET, OP_SIGN_CLEAR: dedicatedFlag = `BSX_FLAG_S;
      OP_OVF_SET, OP_OVF_CLEAR: dedicatedFlag = `BSX_FLAG_V;
      OP_TFLAG_SET, OP_TFLAG_CLEAR: dedicatedFlag = `BSX_FLAG_T;
      OP_HALF_SET, OP_HALF_CLEAR: dedicatedFlag = `BSX_FLAG_H;
      default: dedicatedFlag = `BSX_FLAG_I;
    endcase
  endfunction

  function automatic logic isDedicatedSet(input bsx_op_t op);
    isDedicatedSet = (op == OP_CARRY_SET) || (op == OP_NEG_SET) || (op == OP_ZERO_SET)
      || (op == OP_SIGN_SET) || (op == OP_OVF_SET) || (op == OP_TFLAG_SET) || (op == OP_HALF_SET);
  endfunction

  function automatic logic isDedicatedClear(input bsx_op_t op);
    isDedicatedClear = (op == OP_CARRY_CLEAR) || (op == OP_NEG_CLEAR) || (op == OP_ZERO_CLEAR)
      || (op == OP_SIGN_CLEAR) || (op == OP_OVF_CLEAR) || (op == OP_TFLAG_CLEAR) || (op == OP_HALF_CLEAR);
  endfunction

  // Shift flags share one form so every shift agrees on Z N V
  function automatic logic [7:0] shiftFlags(input logic [7:0] old, input logic [7:0] res, input logic carry,
    input logic updH, input logic half);
    logic [7:0] f;
    f = old;
    f[`BSX_FLAG_C] = carry;
    f[`BSX_FLAG_Z] = (res == 8'h00); // RULE_16
    f[`BSX_FLAG_N] = res[7]; // RULE_16
    f[`BSX_FLAG_V] = res[7] ^ carry; // RULE_16
    if (updH)
      f[`BSX_FLAG_H] = half;
    shiftFlags = f;
  endfunction

  // ==========================================
  // Handshake
  // One operation a cycle; only a memory controller access holds decode off
  assign opReady = !nvmStall;
  assign take = opValid && opReady;
  assign nvmStart = take && opReq.nvmAccess;

  // ==========================================
  // Operation decode
  always_comb
  begin
    flags_d = flags_q;
    result_d = '0;
    ctl_d = '0;
    if (take && !opReq.nvmAccess)
    begin
      unique case (opReq.opCode)
        OP_IDLE:
        begin
          flags_d = flags_q; // RULE_13
        end
        OP_LOGICAL_LEFT_SHIFT:
        begin
          result_d.destWrite = 1'b1;
          result_d.destData = {opReq.destData[6:0], 1'b0}; // RULE_01
          flags_d = shiftFlags(flags_q, {opReq.destData[6:0], 1'b0}, opReq.destData[7], 1'b1,
            opReq.destData[3]); // RULE_01
        end
        OP_LOGICAL_RIGHT_SHIFT:
        begin
          result_d.destWrite = 1'b1;
          result_d.destData = {1'b0, opReq.destData[7:1]}; // RULE_02
          flags_d = shiftFlags(flags_q, {1'b0, opReq.destData[7:1]}, opReq.destData[0], 1'b0, 1'b0); // RULE_02
        end
        OP_ROTATE_LEFT_CARRY:
        begin
          result_d.destWrite = 1'b1;
          result_d.destData = {opReq.destData[6:0], flags_q[`BSX_FLAG_C]}; // RULE_03
          flags_d = shiftFlags(flags_q, {opReq.destData[6:0], flags_q[`BSX_FLAG_C]}, opReq.destData[7],
            1'b1, opReq.destData[3]); // RULE_03
        end
        OP_ROTATE_RIGHT_CARRY:
        begin
          result_d.destWrite = 1'b1;
          result_d.destData = {flags_q[`BSX_FLAG_C], opReq.destData[7:1]}; // RULE_04
          flags_d = shiftFlags(flags_q, {flags_q[`BSX_FLAG_C], opReq.destData[7:1]}, opReq.destData[0],
            1'b0, 1'b0); // RULE_04
        end
        OP_ARITH_RIGHT_SHIFT:
        begin
          result_d.destWrite = 1'b1;
          result_d.destData = {opReq.destData[7], opReq.destData[7:1]}; // RULE_05
          flags_d = shiftFlags(flags_q, {opReq.destData[7], opReq.destData[7:1]}, opReq.destData[0],
            1'b0, 1'b0); // RULE_17
        end
        OP_NIBBLE_EXCHANGE:
        begin
          result_d.destWrite = 1'b1;
          result_d.destData = {opReq.destData[3:0], opReq.destData[7:4]}; // RULE_06
        end
        OP_IO_BIT_SET:
        begin
          result_d.ioWrite = 1'b1;
          result_d.ioData = opReq.ioData | (8'h01 << opReq.bitSel); // RULE_07
        end
        OP_IO_BIT_CLEAR:
        begin
          result_d.ioWrite = 1'b1;
          result_d.ioData = opReq.ioData & ~(8'h01 << opReq.bitSel); // RULE_07
        end
        OP_BIT_TO_TRANSFER_FLAG:
        begin
          flags_d[`BSX_FLAG_T] = opReq.srcData[opReq.bitSel]; // RULE_08
        end
        OP_TRANSFER_FLAG_TO_BIT:
        begin
          result_d.destWrite = 1'b1;
          result_d.destData = opReq.destData;
          result_d.destData[opReq.bitSel] = flags_q[`BSX_FLAG_T]; // RULE_09
        end
        OP_GENERIC_FLAG_SET:
        begin
          flags_d[opReq.bitSel] = 1'b1; // RULE_10
        end
        OP_GENERIC_FLAG_CLEAR:
        begin
          flags_d[opReq.bitSel] = 1'b0; // RULE_10
        end
        OP_CARRY_SET, OP_NEG_SET, OP_ZERO_SET, OP_SIGN_SET, OP_OVF_SET, OP_TFLAG_SET, OP_HALF_SET,
        OP_CARRY_CLEAR, OP_NEG_CLEAR, OP_ZERO_CLEAR, OP_SIGN_CLEAR, OP_OVF_CLEAR, OP_TFLAG_CLEAR,
        OP_HALF_CLEAR:
        begin
          if (isDedicatedSet(opReq.opCode))
            flags_d[dedicatedFlag(opReq.opCode)] = 1'b1; // RULE_11
          else if (isDedicatedClear(opReq.opCode))
            flags_d[dedicatedFlag(opReq.opCode)] = 1'b0; // RULE_11
        end
        OP_GLOBAL_IRQ_ENABLE:
        begin
          flags_d[`BSX_FLAG_I] = 1'b1; // RULE_12
        end
        OP_GLOBAL_IRQ_DISABLE:
        begin
          flags_d[`BSX_FLAG_I] = 1'b0; // RULE_12
        end
        OP_BREAKPOINT:
        begin
          ctl_d.breakpoint = 1'b1; // RULE_14
        end
        OP_SLEEP_ENTRY:
        begin
          ctl_d.sleepEntry = 1'b1; // RULE_14
        end
        OP_WATCHDOG_RESTART:
        begin
          ctl_d.watchdogRestart = 1'b1; // RULE_14
        end
        default:
        begin
          flags_d = flags_q;
        end
      endcase
    end
  end

  // ==========================================
  // Flag register
  // A software write in the same cycle as an operation wins whole; the core never issues both
  always_ff @(posedge sysClk or negedge nrst)
  begin
    if (!nrst)
      flags_q <= `BSX_FLAGS_RST;
    else if (regWr && (regAddr == `BSX_OFS_FLAGS))
      flags_q <= regWrData;
    else
      flags_q <= flags_d;
  end

  // ==========================================
  // Results, all registered one cycle after the request is taken
  always_ff @(posedge sysClk or negedge nrst)
  begin
    if (!nrst)
    begin
      result_q <= '0;
      ioAddr_q <= '0;
    end
    else
    begin
      result_q <= result_d;
      if (take)
        ioAddr_q <= ioAddr;
    end
  end

  always_ff @(posedge sysClk or negedge nrst)
  begin
    if (!nrst)
      ctl_q <= '0;
    else
      ctl_q <= ctl_d;
  end

  // ==========================================
  // Memory controller wait
  always_ff @(posedge sysClk or negedge nrst)
  begin
    if (!nrst)
      nvmWait_q <= WaitW'(`BSX_NVM_WAIT_RST);
    else if (regWr && (regAddr == `BSX_OFS_NVM_WAIT))
      nvmWait_q <= regWrData[WaitW-1:0];
  end

  bsx_nvm_wait #(
    .CntW(WaitW)
  ) uWait (
    .sysClk(sysClk),
    .nrst(nrst),
    .start(nvmStart),
    .waitCycles(nvmWait_q),
    .ctrlBusy(nvmBusy),
    .stall(nvmStall),
    .done(nvmDone)
  ); // RULE_15

  // ==========================================
  // Register read port
  // Data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sysClk or negedge nrst)
  begin
    if (!nrst)
      rdData_q <= 8'h00;
    else if (regRd)
    begin
      unique case (regAddr)
        `BSX_OFS_FLAGS: rdData_q <= flags_q;
        `BSX_OFS_NVM_WAIT: rdData_q <= 8'(nvmWait_q);
        `BSX_OFS_STATUS: rdData_q <= {7'h00, nvmStall};
        default: rdData_q <= 8'h00;
      endcase
    end
    else
      rdData_q <= 8'h00;
  end

  assign result = result_q;
  assign ioAddrOut = ioAddr_q;
  assign ctlReq = ctl_q;
  assign flags = flags_q;
  assign regRdData = rdData_q;

endmodule // bsx_exec_unit
`default_nettype wire

// [core/bsx_nvm_wait.sv]
// Extra wait cycles for data accesses routed through the memory controller
`timescale 1ns/1ns
`default_nettype none
`include "bsx_defines.svh"

module bsx_nvm_wait
  import bsx_pkg::*;
#(
  parameter int CntW = 4
)
(
  // Clock and reset
  input wire logic sysClk,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic [CntW-1:0] waitCycles,
  input wire logic ctrlBusy,
  // Status
  output logic stall,
  output logic done
);

  typedef enum logic {
    ST_IDLE,
    ST_WAIT
  } bsx_wait_st_t;

  bsx_wait_st_t state_q;
  logic [CntW-1:0] cnt_q;
  logic done_q;
  logic [CntW-1:0] loadCnt;

  // ==========================================
  // Never fewer than the least wait, even if software wrote zero
  assign loadCnt = (waitCycles < CntW'(`BSX_NVM_WAIT_MIN_CYC)) ? CntW'(`BSX_NVM_WAIT_MIN_CYC) : waitCycles; // RULE_15

  always_ff @(posedge sysClk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            state_q <= ST_WAIT;
            cnt_q <= loadCnt;
          end
        end
        ST_WAIT:
        begin
          if (cnt_q > CntW'(1))
            cnt_q <= cnt_q - CntW'(1);
          else if (!ctrlBusy) // RULE_15
            state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sysClk or negedge nrst)
  begin
    if (!nrst)
      done_q <= 1'b0;
    else
      done_q <= (state_q == ST_WAIT) && (cnt_q <= CntW'(1)) && !ctrlBusy;
  end

  assign stall = (state_q == ST_WAIT);
  assign done = done_q;

endmodule // bsx_nvm_wait
`default_nettype wire

// [core/bsx_pkg.sv]
// Types shared by the bit/shift/flag execution unit
package bsx_pkg;

  // ==========================================
  // Operations presented by the decode stage
  typedef enum logic [4:0] {
    OP_IDLE,
    OP_LOGICAL_LEFT_SHIFT,
    OP_LOGICAL_RIGHT_SHIFT,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_RIGHT_SHIFT,
    OP_NIBBLE_EXCHANGE,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_BIT,
    OP_GENERIC_FLAG_SET,
    OP_GENERIC_FLAG_CLEAR,
    OP_CARRY_SET,
    OP_CARRY_CLEAR,
    OP_NEG_SET,
    OP_NEG_CLEAR,
    OP_ZERO_SET,
    OP_ZERO_CLEAR,
    OP_SIGN_SET,
    OP_SIGN_CLEAR,
    OP_OVF_SET,
    OP_OVF_CLEAR,
    OP_TFLAG_SET,
    OP_TFLAG_CLEAR,
    OP_HALF_SET,
    OP_HALF_CLEAR,
    OP_GLOBAL_IRQ_ENABLE,
    OP_GLOBAL_IRQ_DISABLE,
    OP_BREAKPOINT,
    OP_SLEEP_ENTRY,
    OP_WATCHDOG_RESTART
  } bsx_op_t;

  // ==========================================
  // Request from decode
  typedef struct packed {
    bsx_op_t opCode;
    logic [2:0] bitSel;
    logic nvmAccess;
    logic [7:0] destData;
    logic [7:0] srcData;
    logic [7:0] ioData;
  } bsx_req_t;

  // ==========================================
  // Result towards the register file and I/O space
  typedef struct packed {
    logic destWrite;
    logic [7:0] destData;
    logic ioWrite;
    logic [7:0] ioData;
  } bsx_res_t;

  // Single-cycle requests to neighbouring core logic
  typedef struct packed {
    logic watchdogRestart;
    logic breakpoint;
    logic sleepEntry;
  } bsx_ctl_t;

endpackage

// [tb/bsx_decode_model.sv]
// Decode stage model that presents requests and holds them until taken
`timescale 1ns/1ns
`default_nettype none
module bsx_decode_model
  import bsx_pkg::*;
(
  // Clock and reset
  input wire logic sysClk,
  input wire logic nrst,
  // From bench
  input wire logic issue,
  input wire bsx_req_t reqIn,
  // Towards the unit
  input wire logic opReady,
  output logic opValid,
  output bsx_req_t opReq
);
  always_ff @(posedge sysClk or negedge nrst)
  begin
    if (!nrst)
    begin
      opValid <= 1'b0;
      opReq <= '0;
    end
    else if (issue)
    begin
      opValid <= 1'b1;
      opReq <= reqIn;
    end
    else if (opReady)
    begin
      // Released fields show the request inverted, flipping back to it every other cycle while idle
      opValid <= 1'b0;
      opReq <= ~opReq;
    end
  end
endmodule // bsx_decode_model
`default_nettype wire

// [tb/bsx_exec_unit_monitor.sv]
// Port checker of the bit/shift/flag execution unit
`timescale 1ns/1ns
`default_nettype none
module bsx_exec_unit_monitor
  import bsx_pkg::*;
#(
  parameter int IoAddrW = 5,
  parameter int WaitW = 4
)
(
  // Clock and reset
  input wire logic sysClk,
  input wire logic nrst,
  // Decode side
  input wire logic opValid,
  input wire bsx_req_t opReq,
  input wire logic opReady,
  // Results
  input wire bsx_res_t result,
  input wire logic nvmDone,
  input wire bsx_ctl_t ctlReq,
  input wire logic [7:0] flags
);
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // Request and flags of the previous cycle
  bsx_req_t pr;
  logic [7:0] pf;
  always_ff @(posedge sysClk)
  begin
    pr <= opReq;
    pf <= flags;
  end
  sequence tk(bsx_op_t op);
    opValid && opReady && !opReq.nvmAccess && opReq.opCode == op;
  endsequence
  // ==========================================
  // Assertions
  a_left_shift: assert property (tk(OP_LOGICAL_LEFT_SHIFT) |=>
    result.destWrite && result.destData == pr.destData << 1 && flags[0] == pr.destData[7]) else $error("Left shift");
  a_right_shift: assert property (tk(OP_LOGICAL_RIGHT_SHIFT) |=>
    result.destData == pr.destData >> 1 && flags[0] == pr.destData[0] && flags[5] == pf[5]) else $error("Right shift");
  a_rotate_left: assert property (tk(OP_ROTATE_LEFT_CARRY) |=>
    result.destData == {pr.destData[6:0], pf[0]} && flags[0] == pr.destData[7]) else $error("Rotate left");
  a_rotate_right: assert property (tk(OP_ROTATE_RIGHT_CARRY) |=>
    result.destData == {pf[0], pr.destData[7:1]} && flags[0] == pr.destData[0]) else $error("Rotate right");
  a_arith_shift: assert property (tk(OP_ARITH_RIGHT_SHIFT) |=>
    result.destData == {pr.destData[7], pr.destData[7:1]} && flags[0] == pr.destData[0]) else $error("Arith shift");
  a_shift_flags: assert property (opValid && opReady && !opReq.nvmAccess &&
    opReq.opCode inside {[OP_LOGICAL_LEFT_SHIFT:OP_ARITH_RIGHT_SHIFT]} |=> flags[1] == (result.destData == 8'h00)
    && flags[2] == result.destData[7] && flags[3] == (flags[2] ^ flags[0])) else $error("Shift flags");
  a_swap_nibble: assert property (tk(OP_NIBBLE_EXCHANGE) |=>
    result.destData == {pr.destData[3:0], pr.destData[7:4]} && flags == pf) else $error("Nibble exchange");
  a_io_set: assert property (tk(OP_IO_BIT_SET) |=>
    result.ioWrite && result.ioData == (pr.ioData | 8'h01 << pr.bitSel) && flags == pf) else $error("I/O bit set");
  a_bit_store: assert property (tk(OP_BIT_TO_TRANSFER_FLAG) |=>
    flags[6] == pr.srcData[pr.bitSel] && ((flags ^ pf) & 8'hBF) == 8'h00) else $error("Bit store");
  a_idle_quiet: assert property (tk(OP_IDLE) |=>
    !result.destWrite && !result.ioWrite && flags == pf) else $error("Idle changed state");
  a_watchdog_pulse: assert property (tk(OP_WATCHDOG_RESTART) |=>
    ctlReq.watchdogRestart && flags == pf ##1 !ctlReq.watchdogRestart) else $error("Watchdog pulse");
  a_nvm_stall: assert property (opValid && opReady && opReq.nvmAccess |=>
    !opReady [*1]) else $error("No wait");
  // ==========================================
  // Cover
  c_nvm_done: cover property (nvmDone);
  c_bit_load: cover property (tk(OP_TRANSFER_FLAG_TO_BIT));
  c_sleep: cover property (ctlReq.sleepEntry);
endmodule // bsx_exec_unit_monitor
bind bsx_exec_unit bsx_exec_unit_monitor #(.IoAddrW(IoAddrW), .WaitW(WaitW)) bsx_exec_unit_monitor_inst (
  .sysClk(sysClk), .nrst(nrst), .opValid(opValid), .opReq(opReq), .opReady(opReady),
  .result(result), .nvmDone(nvmDone), .ctlReq(ctlReq), .flags(flags));
`default_nettype wire

// [tb/tb_bsx_exec_unit.sv]
// Self-checking bench of the bit/shift/flag execution unit
`timescale 1ns/1ns
`default_nettype none
`include "bsx_defines.svh"
module tb_bsx_exec_unit;
  import bsx_pkg::*;
  logic sysClk = 1'b0;
  logic nrst = 1'b0;
  logic issue, regWr, regRd, nvmBusy, opValid, opReady, nvmDone;
  bsx_req_t reqIn, opReq;
  bsx_res_t result;
  bsx_ctl_t ctlReq;
  logic [4:0] ioAddr, ioAddrOut;
  logic [`BSX_REG_ADDR_W-1:0] regAddr;
  logic [7:0] regWrData, flags, regRdData;
  int fails = 0;
  int checks = 0;
  always #25 sysClk = ~sysClk;
  bsx_decode_model bsx_decode_model_inst (.sysClk(sysClk), .nrst(nrst), .issue(issue), .reqIn(reqIn),
    .opReady(opReady), .opValid(opValid), .opReq(opReq));
  bsx_exec_unit #(.IoAddrW(5), .WaitW(4)) bsx_exec_unit_inst (.sysClk(sysClk), .nrst(nrst), .opValid(opValid),
    .opReq(opReq), .ioAddr(ioAddr), .opReady(opReady), .nvmBusy(nvmBusy), .result(result), .ioAddrOut(ioAddrOut),
    .nvmDone(nvmDone), .ctlReq(ctlReq), .flags(flags), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData));
  // ==========================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
    @(posedge sysClk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sysClk);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [1:0] a, input logic [7:0] exp);
    @(posedge sysClk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sysClk);
    regRd <= 1'b0;
    #1 check(regRdData, exp);
  endtask
  // Returns just after the edge that takes the request, where results stand
  task automatic doOp(input bsx_op_t op, input logic [2:0] bs, input logic nv, input logic [7:0] d, s, io);
    int n;
    n = 0;
    @(posedge sysClk);
    reqIn <= '{op, bs, nv, d, s, io};
    issue <= 1'b1;
    @(posedge sysClk);
    issue <= 1'b0;
    #1;
    while (opReady !== 1'b1 && n < 50)
    begin
      @(posedge sysClk);
      #1 n++;
    end
    @(posedge sysClk);
    #1;
  endtask
  function automatic logic [15:0] shx(bsx_op_t op, logic [7:0] d, logic [7:0] f);
    logic [7:0] r;
    logic [7:0] g;
    logic c;
    g = f;
    case (op)
      OP_LOGICAL_LEFT_SHIFT: {c, r} = {d, 1'b0};
      OP_ROTATE_LEFT_CARRY: {c, r} = {d, f[0]};
      OP_LOGICAL_RIGHT_SHIFT: {r, c} = {1'b0, d};
      OP_ROTATE_RIGHT_CARRY: {r, c} = {f[0], d};
      default: {r, c} = {d[7], d};
    endcase
    if (op == OP_LOGICAL_LEFT_SHIFT || op == OP_ROTATE_LEFT_CARRY)
      g[5] = d[3];
    g[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
    return {g, r};
  endfunction
  // ==========================================
  // Scenarios
  task automatic test_regs;
    regRead(`BSX_OFS_FLAGS, `BSX_FLAGS_RST);
    regRead(`BSX_OFS_NVM_WAIT, {4'h0, `BSX_NVM_WAIT_RST});
    regWrite(2'h3, 8'hFF);
    regRead(2'h3, 8'h00);
    regRead(`BSX_OFS_STATUS, 8'h00);
  endtask
  task automatic test_shifts;
    logic [7:0] dv [3] = '{8'h81, 8'h00, 8'h4C};
    logic [15:0] e;
    for (int i = 1; i <= 5; i++)
      for (int j = 0; j < 3; j++)
      begin
        regWrite(`BSX_OFS_FLAGS, j[0] ? 8'h21 : 8'h00);
        e = shx(bsx_op_t'(i), dv[j], j[0] ? 8'h21 : 8'h00);
        doOp(bsx_op_t'(i), 3'h0, 1'b0, dv[j], 8'h00, 8'h00);
        check({7'h00, result.destWrite}, 8'h01);
        check(result.destData, e[7:0]);
        check(flags, e[15:8]);
      end
  endtask
  task automatic test_swap_tbit;
    regWrite(`BSX_OFS_FLAGS, 8'h5A);
    doOp(OP_NIBBLE_EXCHANGE, 3'h0, 1'b0, 8'h3C, 8'h00, 8'h00);
    check(result.destData, 8'hC3);
    check(flags, 8'h5A);
    regWrite(`BSX_OFS_FLAGS, 8'h00);
    doOp(OP_BIT_TO_TRANSFER_FLAG, 3'h5, 1'b0, 8'hFF, 8'h20, 8'h00);
    check(flags, 8'h40);
    doOp(OP_TRANSFER_FLAG_TO_BIT, 3'h2, 1'b0, 8'h81, 8'h00, 8'h00);
    check(result.destData, 8'h85);
    check(flags, 8'h40);
    doOp(OP_BIT_TO_TRANSFER_FLAG, 3'h4, 1'b0, 8'h00, 8'hEF, 8'h00);
    check(flags, 8'h00);
  endtask
  task automatic test_io;
    for (int b = 0; b < 8; b++)
    begin
      ioAddr <= 5'(b + 3);
      doOp(OP_IO_BIT_SET, 3'(b), 1'b0, 8'h00, 8'h00, 8'h00);
      check(result.ioData, 8'h01 << b);
      check({3'h0, ioAddrOut}, 8'(b + 3));
      doOp(OP_IO_BIT_CLEAR, 3'(b), 1'b0, 8'h00, 8'h00, 8'hFF);
      check({7'h00, result.ioWrite}, 8'h01);
      check(result.ioData, ~(8'h01 << b));
      check(flags, 8'h00);
    end
  endtask
  task automatic test_flag_ops;
    int pos [8] = '{0, 2, 1, 4, 3, 6, 5, 7};
    for (int k = 0; k < 8; k++)
    begin
      regWrite(`BSX_OFS_FLAGS, 8'h00);
      doOp(OP_GENERIC_FLAG_SET, 3'(pos[k]), 1'b0, 8'h00, 8'h00, 8'h00);
      check(flags, 8'h01 << pos[k]);
      doOp(bsx_op_t'(int'(OP_CARRY_SET) + 2 * k + 1), 3'h0, 1'b0, 8'h00, 8'h00, 8'h00);
      check(flags, 8'h00);
      regWrite(`BSX_OFS_FLAGS, 8'hFF);
      doOp(OP_GENERIC_FLAG_CLEAR, 3'(pos[k]), 1'b0, 8'h00, 8'h00, 8'h00);
      check(flags, ~(8'h01 << pos[k]));
      doOp(bsx_op_t'(int'(OP_CARRY_SET) + 2 * k), 3'h0, 1'b0, 8'h00, 8'h00, 8'h00);
      check(flags, 8'hFF);
    end
  endtask
  task automatic test_ctl;
    bsx_op_t ops [4] = '{OP_IDLE, OP_BREAKPOINT, OP_SLEEP_ENTRY, OP_WATCHDOG_RESTART};
    logic [7:0] hot [4] = '{8'h00, 8'h02, 8'h01, 8'h04};
    regWrite(`BSX_OFS_FLAGS, 8'hA5);
    for (int k = 0; k < 4; k++)
    begin
      doOp(ops[k], 3'h0, 1'b0, 8'h55, 8'h00, 8'h00);
      check({5'h00, ctlReq}, hot[k]);
      check({6'h00, result.destWrite, result.ioWrite}, 8'h00);
      check(flags, 8'hA5);
    end
  endtask
  task automatic test_nvm;
    logic [3:0] w [4] = '{4'h0, 4'h1, 4'h3, 4'h1};
    int n;
    for (int k = 0; k < 4; k++)
    begin
      regWrite(`BSX_OFS_NVM_WAIT, {4'h0, w[k]});
      nvmBusy <= (k == 3);
      doOp(OP_IDLE, 3'h0, 1'b1, 8'h00, 8'h00, 8'h00);
      n = 0;
      while (opReady !== 1'b1 && n < 40)
      begin
        n++;
        if (n == 3)
          nvmBusy <= 1'b0;
        @(posedge sysClk);
        #1;
      end
      check({7'h00, nvmDone}, 8'h01);
      if (k < 3)
        check(8'(n), (w[k] == 4'h0) ? 8'h01 : {4'h0, w[k]});
      else
        // Least wait plus the two cycles that busy is held
        check(8'(n), 8'h03);
    end
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    {issue, regWr, regRd, nvmBusy} = 4'h0;
    reqIn = '0;
    ioAddr = 5'h00;
    regAddr = '0;
    regWrData = 8'h00;
    repeat (3) @(posedge sysClk);
    nrst <= 1'b1;
    test_regs();
    test_shifts();
    test_swap_tbit();
    test_io();
    test_flag_ops();
    test_ctl();
    test_nvm();
    end_of_test();
  end
  initial
  begin
    // Whole run needs a few hundred cycles
    #(50 * 20000);
    fails++;
    end_of_test();
  end
endmodule // tb_bsx_exec_unit
`default_nettype wire
